//--- core/rxd_defines.svh
`ifndef RXD_DEFINES_SVH
`define RXD_DEFINES_SVH

// ----------------------------------------------------------------------------
// descriptor word byte offsets
// ----------------------------------------------------------------------------
`define RXD_OFS_STATUS   32'h0000_0000
`define RXD_OFS_CONTROL  32'h0000_0004
`define RXD_OFS_BUFFER   32'h0000_0008
`define RXD_OFS_NEXT     32'h0000_000C

// ----------------------------------------------------------------------------
// status word fields
// ----------------------------------------------------------------------------
`define RXD_ST_OWN       31
`define RXD_ST_FIRST     30
`define RXD_ST_LAST      29
`define RXD_ST_ERRSUM    25
`define RXD_ST_PORT2     21
`define RXD_ST_PORT1     20
`define RXD_ST_PHYERR    19
`define RXD_ST_OVERSIZE  18
`define RXD_ST_RUNT      17
`define RXD_ST_CRC       16
`define RXD_ST_ETYPE     15
`define RXD_ST_LEN_MSB   10

// ----------------------------------------------------------------------------
// control word fields
// ----------------------------------------------------------------------------
`define RXD_CT_WRAP      25
`define RXD_CT_SIZE_MSB  10

// ----------------------------------------------------------------------------
// frame limits and timing
// ----------------------------------------------------------------------------
`define RXD_MAX_FRAME    16'h05EE
`define RXD_TYPE_LIMIT   16'h05DC
`define RXD_MIN_FRAME    16'h0040
`define RXD_POLL_CYC     8'h40
`define RXD_RESET_WORD   32'h0000_0000

`endif

//--- core/rxd_pkg.sv
package rxd_pkg;

  typedef enum logic [3:0] {
    RXD_IDLE,
    RXD_FETCH,
    RXD_CHECK,
    RXD_POLL,
    RXD_RECV,
    RXD_WR_DATA,
    RXD_WR_STAT
  } rxd_state_e;

  typedef logic [15:0] rxd_count_t;

endpackage : rxd_pkg

//--- core/rxd_frame_mon.sv
`timescale 1ns/1ps
`include "rxd_defines.svh"

module rxd_frame_mon
  import rxd_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic       take,
  input  wire logic [7:0] rx_byte,
  input  wire logic       rx_last,
  input  wire logic       rx_phy_err,
  input  wire logic       rx_coll,
  input  wire logic       rx_crc_err,
  output rxd_count_t      byte_cnt,
  output logic            phy_fault,
  output logic            coll_seen,
  output logic            crc_fail,
  output logic            oversize,
  output logic            runt,
  output logic            ethertype
);

  rxd_count_t cnt_q;
  rxd_count_t type_q;
  logic       err_q;
  logic       coll_q;
  logic       crc_q;
  logic       done_q;

  // ----------------------------------------------------------------------------
  // per-frame statistics, restarted by the first byte after a frame end
  // ----------------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q  <= 16'h0000;
      type_q <= 16'h0000;
      err_q  <= 1'b0;
      coll_q <= 1'b0;
      crc_q  <= 1'b0;
      done_q <= 1'b1;
    end else begin
      if (take) begin
        cnt_q  <= (done_q ? 16'h0001 : cnt_q + 16'h0001);
        done_q <= rx_last;
        if (rx_last) begin
          crc_q <= rx_crc_err;
        end
        if (!done_q && cnt_q == 16'h000C) begin
          type_q[15:8] <= rx_byte;
        end
        if (!done_q && cnt_q == 16'h000D) begin
          type_q[7:0] <= rx_byte;
        end
      end
      // phy fault latched at any point inside the frame, collision only while fewer than 64 bytes are counted
      if (take && done_q) begin
        err_q  <= rx_phy_err;
        coll_q <= rx_coll;
      end else if (!done_q) begin
        err_q  <= err_q | rx_phy_err;
        coll_q <= coll_q | (rx_coll && cnt_q < `RXD_MIN_FRAME);
      end
    end
  end

  assign byte_cnt  = cnt_q;
  assign phy_fault = err_q;
  assign coll_seen = coll_q;
  assign crc_fail  = crc_q;
  assign oversize  = (cnt_q > `RXD_MAX_FRAME);
  assign runt      = coll_q || (cnt_q < `RXD_MIN_FRAME);
  assign ethertype = (type_q > `RXD_TYPE_LIMIT);

endmodule : rxd_frame_mon

//--- core/rxd_ring.sv
// Overview of operation
// - source field bit 20 marks port one, bit 21 port two; bits 23-22 zero.
// - physical-layer fault flag set if a receive error appeared during the frame.
// - oversize flag set for frames longer than 1518 bytes, in last status.
// - oversize frames are written in full, never truncated.
// - runt flag set for frames shorter than 64 bytes or with a collision before byte 64.
// - runt frame data always reaches host buffers; last status is written only when pass-bad-frame is set.
// - CRC failure flag reported in the last descriptor status only.
// - frame-type flag one when length/type field exceeds 1500 and the frame is not a runt.
// - eleven-bit byte count including CRC written in the last status.
// - end-of-ring bit sends the next fetch to the list base address.
// - zero buffer size skips the descriptor and moves on.
// - third descriptor word is the word-aligned buffer write address.
// - fourth descriptor word is the next descriptor address.
// - ownership cleared when the buffer fills or frame completes, unless a runt frame ends with pass-bad-frame clear.
// - error summary is OR of CRC, oversize and runt flags.
// - first-buffer and last-buffer flags mark the frame's end descriptors.
`timescale 1ns/1ps
`include "rxd_defines.svh"

module rxd_ring
  import rxd_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        rx_enable,
  input  wire logic [31:0] ring_base,
  input  wire logic        pass_bad_frame,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        rx_last,
  input  wire logic [1:0]  rx_port,
  input  wire logic        rx_phy_err,
  input  wire logic        rx_coll,
  input  wire logic        rx_crc_err,
  output logic             rx_ready,
  output logic             mem_req,
  output logic             mem_we,
  output logic [31:0]      mem_addr,
  output logic [31:0]      mem_wdata,
  input  wire logic [31:0] mem_rdata,
  input  wire logic        mem_ack,
  output logic             busy
);

  rxd_state_e  state_q;
  logic [31:0] desc_q;
  logic [31:0] first_desc_q;
  logic [31:0] own_word_q;
  logic [31:0] ctrl_q;
  logic [31:0] buf_q;
  logic [31:0] next_q;
  logic [1:0]  widx_q;
  logic [7:0]  poll_q;
  logic [10:0] off_q;
  logic [10:0] fill_q;
  logic [31:0] word_q;
  logic [1:0]  bidx_q;
  logic        end_q;
  logic        first_q;
  logic [1:0]  port_q;
  logic        take;
  logic        flush;
  logic [10:0] size;
  logic [31:0] next_desc;
  logic [31:0] status;
  rxd_count_t  byte_cnt;
  logic        phy_fault;
  logic        crc_fail;
  logic        oversize;
  logic        runt;
  logic        ethertype;

  assign size      = ctrl_q[`RXD_CT_SIZE_MSB:0];
  assign next_desc = ctrl_q[`RXD_CT_WRAP] ? ring_base : next_q;
  // buffer accepts bytes until full; frame length itself is never limited
  assign rx_ready  = (state_q == RXD_RECV) && (fill_q != size);
  assign take      = rx_valid && rx_ready;
  assign flush     = take && (rx_last || bidx_q == 2'h3 || fill_q + 11'h001 == size);
  assign busy      = (state_q != RXD_IDLE);

  // ----------------------------------------------------------------------------
  // frame statistics
  // ----------------------------------------------------------------------------
  rxd_frame_mon u_mon (
    .sys_clk    (sys_clk),
    .rstn       (rstn),
    .take       (take),
    .rx_byte    (rx_byte),
    .rx_last    (rx_last),
    .rx_phy_err (rx_phy_err),
    .rx_coll    (rx_coll),
    .rx_crc_err (rx_crc_err),
    .byte_cnt   (byte_cnt),
    .phy_fault  (phy_fault),
    .coll_seen  (),
    .crc_fail   (crc_fail),
    .oversize   (oversize),
    .runt       (runt),
    .ethertype  (ethertype)
  );

  // ----------------------------------------------------------------------------
  // status word assembly
  // ----------------------------------------------------------------------------
  always_comb begin
    status = `RXD_RESET_WORD;
    status[`RXD_ST_FIRST]  = first_q;
    status[`RXD_ST_LAST]   = end_q;
    status[`RXD_ST_PHYERR] = phy_fault;
    status[`RXD_ST_RUNT]   = runt;
    if (end_q) begin
      status[`RXD_ST_PORT1]           = port_q[0];
      status[`RXD_ST_PORT2]           = port_q[1];
      status[`RXD_ST_OVERSIZE]        = oversize;
      status[`RXD_ST_CRC]             = crc_fail;
      status[`RXD_ST_ERRSUM]          = crc_fail | oversize | runt;
      status[`RXD_ST_ETYPE]           = ethertype & ~runt;
      status[`RXD_ST_LEN_MSB:0]       = byte_cnt[10:0];
    end
  end

  // ----------------------------------------------------------------------------
  // descriptor and frame state machine
  // ----------------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_q      <= RXD_IDLE;
      desc_q       <= `RXD_RESET_WORD;
      first_desc_q <= `RXD_RESET_WORD;
      own_word_q   <= `RXD_RESET_WORD;
      ctrl_q       <= `RXD_RESET_WORD;
      buf_q        <= `RXD_RESET_WORD;
      next_q       <= `RXD_RESET_WORD;
      widx_q       <= 2'h0;
      poll_q       <= 8'h00;
      off_q        <= 11'h000;
      fill_q       <= 11'h000;
      end_q        <= 1'b0;
      first_q      <= 1'b1;
      port_q       <= 2'h0;
    end else begin
      case (state_q)
        RXD_IDLE: begin
          if (rx_enable) begin
            desc_q       <= ring_base;
            first_desc_q <= ring_base;
            widx_q       <= 2'h0;
            state_q      <= RXD_FETCH;
          end
        end
        RXD_FETCH: begin
          if (mem_ack) begin
            widx_q <= widx_q + 2'h1;
            case (widx_q)
              2'h0: own_word_q <= mem_rdata;
              2'h1: ctrl_q     <= mem_rdata;
              2'h2: buf_q      <= mem_rdata;
              default: next_q  <= mem_rdata;
            endcase
            if (widx_q == 2'h3) begin
              state_q <= RXD_CHECK;
            end
          end
        end
        RXD_CHECK: begin
          off_q  <= 11'h000;
          fill_q <= 11'h000;
          if (!own_word_q[`RXD_ST_OWN]) begin
            poll_q  <= `RXD_POLL_CYC;
            state_q <= RXD_POLL;
          end else if (size == 11'h000) begin
            desc_q  <= next_desc;
            if (first_q) begin
              first_desc_q <= next_desc;
            end
            widx_q  <= 2'h0;
            state_q <= RXD_FETCH;
          end else begin
            state_q <= RXD_RECV;
          end
        end
        RXD_POLL: begin
          poll_q <= poll_q - 8'h01;
          if (!rx_enable) begin
            state_q <= RXD_IDLE;
          end else if (poll_q == 8'h01) begin
            widx_q  <= 2'h0;
            state_q <= RXD_FETCH;
          end
        end
        RXD_RECV: begin
          if (take) begin
            fill_q <= fill_q + 11'h001;
            if (rx_last) begin
              end_q  <= 1'b1;
              port_q <= rx_port;
            end
          end
          if (flush) begin
            state_q <= RXD_WR_DATA;
          end
        end
        RXD_WR_DATA: begin
          if (mem_ack) begin
            off_q <= {fill_q[10:2] + (fill_q[1:0] != 2'h0 ? 9'h001 : 9'h000), 2'h0};
            if (end_q && runt && !pass_bad_frame) begin
              end_q   <= 1'b0;
              first_q <= 1'b1;
              desc_q  <= first_desc_q;
              widx_q  <= 2'h0;
              state_q <= RXD_FETCH;
            end else if (end_q || fill_q == size) begin
              state_q <= RXD_WR_STAT;
            end else begin
              state_q <= RXD_RECV;
            end
          end
        end
        RXD_WR_STAT: begin
          if (mem_ack) begin
            desc_q  <= next_desc;
            first_q <= end_q;
            end_q   <= 1'b0;
            if (end_q) begin
              first_desc_q <= next_desc;
            end
            widx_q  <= 2'h0;
            state_q <= rx_enable ? RXD_FETCH : RXD_IDLE;
          end
        end
        default: state_q <= RXD_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // byte packing, little-endian within a word
  // ----------------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      word_q <= `RXD_RESET_WORD;
      bidx_q <= 2'h0;
    end else if (take) begin
      word_q[bidx_q*8 +: 8] <= rx_byte;
      bidx_q <= flush ? 2'h0 : bidx_q + 2'h1;
    end else if (state_q == RXD_WR_DATA && mem_ack) begin
      word_q <= `RXD_RESET_WORD;
    end
  end

  // ----------------------------------------------------------------------------
  // memory master port, registered
  // ----------------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mem_req   <= 1'b0;
      mem_we    <= 1'b0;
      mem_addr  <= `RXD_RESET_WORD;
      mem_wdata <= `RXD_RESET_WORD;
    end else if (mem_req) begin
      if (mem_ack) begin
        mem_req <= 1'b0;
      end
    end else begin
      case (state_q)
        RXD_FETCH: begin
          mem_req  <= 1'b1;
          mem_we   <= 1'b0;
          mem_addr <= desc_q + {28'h000_0000, widx_q, 2'h0};
        end
        RXD_WR_DATA: begin
          mem_req   <= 1'b1;
          mem_we    <= 1'b1;
          mem_addr  <= buf_q + {21'h00_0000, off_q};
          mem_wdata <= word_q;
        end
        RXD_WR_STAT: begin
          mem_req   <= 1'b1;
          mem_we    <= 1'b1;
          mem_addr  <= desc_q + `RXD_OFS_STATUS;
          mem_wdata <= status;
        end
        default: begin
          mem_req <= 1'b0;
          mem_we  <= 1'b0;
        end
      endcase
    end
  end

endmodule : rxd_ring

//--- verification/rxd_ring_checker.sv
`timescale 1ns/1ps
module rxd_ring_checker (
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic        rx_valid,
  input wire logic        rx_ready,
  input wire logic        rx_last,
  input wire logic        rx_crc_err,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic        mem_ack,
  input wire logic [1:0]  rx_port,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic [31:0] mem_rdata
);
  logic [31:0] desc_q, buf_q;
  logic [10:0] size_q, cnt_q, len_q;
  logic [1:0]  port_q;
  logic        crc_q;
  wire rd_ack  = mem_req && mem_ack && !mem_we;
  wire stat_wr = mem_req && mem_we && mem_addr == desc_q;
  wire take    = rx_valid && rx_ready;
  // --------
  // current descriptor and frame trackers
  // --------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      desc_q <= 32'h0;
      size_q <= 11'h0;
      buf_q  <= 32'h0;
    end else if (rd_ack) begin
      if (mem_addr[3:0] == 4'h0) desc_q <= mem_addr;
      if (mem_addr[3:0] == 4'h4) size_q <= mem_rdata[10:0];
      if (mem_addr[3:0] == 4'h8) buf_q <= mem_rdata;
    end
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q  <= 11'h0;
      len_q  <= 11'h0;
      port_q <= 2'h0;
      crc_q  <= 1'b0;
    end else if (take) begin
      cnt_q <= rx_last ? 11'h0 : cnt_q + 11'h1;
      if (rx_last) begin
        len_q  <= cnt_q + 11'h1;
        port_q <= rx_port;
        crc_q  <= rx_crc_err;
      end
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence s_last_stat;
    stat_wr && mem_wdata[29];
  endsequence
  sequence s_data_wr;
    mem_req && mem_we && mem_addr != desc_q;
  endsequence
  // --------
  // assertions
  // --------
  chk_req_hold:
    assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_wdata))
    else $error("memory request changed before ack");
  chk_req_gap:
    assert property (mem_req && mem_ack |=> !mem_req) else $error("no idle cycle after ack");
  chk_own_clear:
    assert property (stat_wr |-> !mem_wdata[31]) else $error("status write keeps ownership");
  chk_errsum_or:
    assert property (s_last_stat |-> mem_wdata[25] == |mem_wdata[18:16]) else $error("error summary wrong");
  chk_port_bits:
    assert property (s_last_stat |-> mem_wdata[23:20] == {2'b00, port_q}) else $error("source port wrong");
  chk_crc_flag:
    assert property (s_last_stat |-> mem_wdata[16] == crc_q) else $error("crc flag wrong");
  chk_buf_target:
    assert property (s_data_wr |-> mem_addr - buf_q < {21'h0, size_q}) else $error("data outside buffer");
  chk_len_field:
    assert property (s_last_stat |-> mem_wdata[25] || mem_wdata[10:0] == len_q) else $error("length wrong");
endmodule : rxd_ring_checker

//--- verification/rxd_mem_model.sv
`timescale 1ns/1ps
module rxd_mem_model (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic [3:0]  lat,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  output logic      [31:0] mem_rdata,
  output logic             mem_ack
);
  logic [31:0] mem [0:1023];
  logic [3:0]  cnt_q;
  // --------
  // answer after lat cycles, read data scrambled outside ack
  // --------
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q     <= 4'h0;
      mem_ack   <= 1'b0;
      mem_rdata <= 32'h0;
    end else begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack && cnt_q >= lat) begin
        mem_ack <= 1'b1;
        cnt_q   <= 4'h0;
        if (mem_we) mem[mem_addr[11:2]] <= mem_wdata;
        else mem_rdata <= mem[mem_addr[11:2]];
      end else if (mem_req && !mem_ack) begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule : rxd_mem_model

//--- verification/rxd_ring_tb.sv
`timescale 1ns/1ps
module rxd_ring_tb;
  logic        sys_clk, rstn, rx_enable, pass_bad_frame, rx_valid, rx_last, rx_phy_err, rx_coll, rx_crc_err;
  logic        rx_ready, mem_req, mem_we, mem_ack, busy;
  logic [1:0]  rx_port;
  logic [3:0]  lat;
  logic [7:0]  rx_byte;
  logic [31:0] ring_base, mem_addr, mem_wdata, mem_rdata;
  int          fail_count, total_checks;
  localparam logic [31:0] M_LAST = 32'hE2FF_87FF;

  rxd_ring DUT (.sys_clk, .rstn, .rx_enable, .ring_base, .pass_bad_frame, .rx_valid, .rx_byte, .rx_last, .rx_port,
    .rx_phy_err, .rx_coll, .rx_crc_err, .rx_ready, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack,
    .busy);
  rxd_mem_model MEM (.sys_clk, .rstn, .lat, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack);

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // --------
  // helpers
  // --------
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic give_verdict;
    if (fail_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict
  function automatic logic [7:0] fb(int i, logic [15:0] ty);
    return (i == 12) ? ty[15:8] : (i == 13) ? ty[7:0] : i[7:0] ^ 8'hA5;
  endfunction : fb
  task automatic set_desc(int a, logic wrap, logic [10:0] size, logic [31:0] bufa, logic [31:0] nxt);
    MEM.mem[a/4]   = 32'h8000_0000;
    MEM.mem[a/4+1] = {6'h00, wrap, 14'h0000, size};
    MEM.mem[a/4+2] = bufa;
    MEM.mem[a/4+3] = nxt;
  endtask : set_desc
  task automatic send(int len, logic [1:0] port, logic [15:0] ty, int phy_at, int coll_at, logic crc);
    int w;
    @(negedge sys_clk);
    for (int i = 0; i < len; i++) begin
      rx_valid   = 1'b1;
      rx_byte    = fb(i, ty);
      rx_last    = (i == len - 1);
      rx_port    = port;
      rx_phy_err = (i == phy_at);
      rx_coll    = (i == coll_at);
      rx_crc_err = crc;
      w = 0;
      #1;
      while (rx_ready !== 1'b1 && w++ < 5000) @(negedge sys_clk) #1;
      @(negedge sys_clk);
    end
    rx_valid   = 1'b0;
    rx_last    = 1'b0;
    rx_phy_err = 1'b0;
    rx_coll    = 1'b0;
  endtask : send
  task automatic wait_own(int a);
    int w;
    w = 0;
    while (MEM.mem[a/4][31] !== 1'b0 && w++ < 20000) @(negedge sys_clk);
  endtask : wait_own
  // --------
  // scenarios
  // --------
  task automatic t_single;
    send(68, 2'b01, 16'h05DC, -1, -1, 1'b0);
    wait_own(0);
    check("a_status", MEM.mem[0] & M_LAST, 32'h6010_0044);
    check("a_tail", MEM.mem[80], {fb(67, 16'h05DC), fb(66, 16'h05DC), fb(65, 16'h05DC), fb(64, 16'h05DC)});
  endtask : t_single
  task automatic t_chain;
    lat = 4'h5;
    send(80, 2'b10, 16'h0040, 10, -1, 1'b0);
    wait_own(32'h30);
    lat = 4'h1;
    check("b_first", MEM.mem[8] & 32'hE008_0000, 32'h4008_0000);
    check("b_last", MEM.mem[12] & M_LAST, 32'h2028_0050);
    check("b_data", MEM.mem[192], {fb(67, 16'h0040), fb(66, 16'h0040), fb(65, 16'h0040), fb(64, 16'h0040)});
  endtask : t_chain
  task automatic t_runt;
    int w;
    pass_bad_frame = 1'b0;
    send(70, 2'b10, 16'h0800, -1, 5, 1'b0);
    w = 0;
    while (!(mem_req === 1'b1 && mem_we === 1'b0 && mem_addr === 32'h40) && w++ < 5000) @(negedge sys_clk);
    pass_bad_frame = 1'b1;
    send(40, 2'b01, 16'h0800, -1, -1, 1'b0);
    wait_own(32'h40);
    check("d_runt", MEM.mem[16] & 32'hE2FF_0000, 32'h6212_0000);
  endtask : t_runt
  task automatic t_oversize;
    send(1522, 2'b01, 16'h0800, -1, -1, 1'b0);
    wait_own(32'h50);
    check("e_status", MEM.mem[20] & 32'hE2FF_8000, 32'h6214_8000);
    check("e_tail", MEM.mem[892], {16'h0000, fb(1521, 16'h0800), fb(1520, 16'h0800)});
  endtask : t_oversize
  task automatic t_wrap;
    set_desc(0, 1'b0, 11'h080, 32'h100, 32'h10);
    send(64, 2'b10, 16'h05DD, -1, -1, 1'b1);
    wait_own(0);
    check("c_status", MEM.mem[0] & 32'hE2FF_8000, 32'h6221_8000);
  endtask : t_wrap
  // engine walks past the empty slot to the host-owned one, then parks when disabled
  task automatic t_drain;
    repeat (150) @(negedge sys_clk);
    rx_enable = 1'b0;
    repeat (150) @(negedge sys_clk);
    check("f_addr", mem_addr, 32'h0000_002C);
    check("f_idle", {30'h0, busy, rx_ready}, 32'h0000_0000);
  endtask : t_drain

  initial begin
    {rstn, rx_enable, rx_valid, rx_last, rx_phy_err, rx_coll, rx_crc_err} = 7'h00;
    {rx_port, rx_byte, ring_base} = 42'h0;
    pass_bad_frame = 1'b1;
    lat = 4'h1;
    fail_count = 0;
    total_checks = 0;
    for (int i = 0; i < 1024; i++) MEM.mem[i] = 32'h0;
    set_desc(32'h00, 1'b0, 11'h080, 32'h100, 32'h10);
    set_desc(32'h10, 1'b0, 11'h000, 32'h180, 32'h20);
    set_desc(32'h20, 1'b0, 11'h040, 32'h200, 32'h30);
    set_desc(32'h30, 1'b0, 11'h040, 32'h300, 32'h40);
    set_desc(32'h40, 1'b0, 11'h080, 32'h400, 32'h50);
    set_desc(32'h50, 1'b1, 11'h7FC, 32'h800, 32'h60);
    repeat (20) @(negedge sys_clk);
    rstn = 1'b1;
    rx_enable = 1'b1;
    t_single;
    t_chain;
    t_runt;
    t_oversize;
    t_wrap;
    t_drain;
    give_verdict;
  end
  initial begin
    repeat (50000) @(posedge sys_clk);
    fail_count++;
    give_verdict;
  end
endmodule : rxd_ring_tb

bind rxd_ring rxd_ring_checker u_chk (.sys_clk, .rstn, .rx_valid, .rx_ready, .rx_last, .rx_crc_err, .mem_req,
  .mem_we, .mem_ack, .rx_port, .mem_addr, .mem_wdata, .mem_rdata);
